// ==== hdl/lccd_byte_store.sv ====
`timescale 1ns/1ps
`default_nettype none
module lccd_byte_store #(
  parameter int               N_BYTES = 20,
  parameter logic [8*N_BYTES-1:0] DFLT = '0
) (
  // clock and reset
  input  wire  logic                 i_clk,
  input  wire  logic                 i_reset_n,
  input  wire  logic                 i_clk_en,
  // lane writes
  input  wire  logic [3:0]           i_lane_we,
  input  wire  logic [19:0]          i_lane_idx,
  input  wire  logic [31:0]          i_lane_data,
  // stored bytes
  output logic       [8*N_BYTES-1:0] o_bytes
);
  genvar j;
  generate
    for (j = 0; j < N_BYTES; j++) begin : g_byte
      logic       hit;
      logic [7:0] val;
      logic [7:0] byte_q;
      always_comb begin
        hit = 1'b0;
        val = 8'h00;
        for (int l = 0; l < 4; l++) begin
          if (i_lane_we[l] && (i_lane_idx[5*l +: 5] == 5'(j))) begin
            hit = 1'b1;
            val = i_lane_data[8*l +: 8];
          end
        end
      end
      // bytes not addressed keep their value
      always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
          byte_q <= DFLT[8*j +: 8];
        end else if (i_clk_en && hit) begin
          byte_q <= val;
        end
      end
      // one flop per byte, so no two processes share the output word
      assign o_bytes[8*j +: 8] = byte_q;
    end
  endgenerate
endmodule
`default_nettype wire

// ==== hdl/lccd_params.svh ====
// Notes on behaviour
// - opcode bits 18..16 equal to 1h select the station address load.
// - station address of zero to six bytes, length from config, stored from block.
// - lowest address bit is never checked or forced; any value is used as is.
// - parameter load writes only the counted bytes, byte 0 included; others keep values.
// - legacy mode clamps the parameter count into the range four to twelve.
// - legacy mode keeps the extended serial-side features switched off.
// - newer modes use defaults for the two extra bytes until loaded.
// - opcode bits 18..16 equal to 2h select the parameter load.
// - aborted bit is one when an abort ends the command, else zero.
// - byte 0 bit 7 enables the prefetched mark, newer modes only.
// - byte 2 bit 7 keeps bad frames in memory; byte 2 resets to 40h.
// - completion and busy bits are written together in one status write.
// - after reset the station address is all ones until loaded.
`ifndef LCCD_PARAMS_SVH
`define LCCD_PARAMS_SVH

// --------------------------------------------------------------------
// command word
// --------------------------------------------------------------------
`define LCCD_OPC_LO      16
`define LCCD_OPC_HI      18
`define LCCD_OPC_ADDR    3'h1
`define LCCD_OPC_CFG     3'h2
`define LCCD_BIT_LAST    31
`define LCCD_BIT_S       30
`define LCCD_BIT_I       29
`define LCCD_ST_C        15
`define LCCD_ST_B        14
`define LCCD_ST_OK       13
`define LCCD_ST_A        12

// --------------------------------------------------------------------
// byte layout and counts
// --------------------------------------------------------------------
`define LCCD_OFF_SEG     6'h06
`define LCCD_OFF_LIN     6'h08
`define LCCD_CNT_LEG_MAX 5'h0C
`define LCCD_CNT_LEG_MIN 5'h04
`define LCCD_CNT_NEW_MAX 5'h0E
`define LCCD_ADDR_MAX    5'h06
`define LCCD_ADDR_BASE   5'h0E
`define LCCD_ALL_BYTES   20
`define LCCD_DFLT        160'hFFFFFFFFFFFF_0000_0040_0000_F200_6000_2640_C800
`define LCCD_PREF_POS    7
`define LCCD_QLIM_POS    8
`define LCCD_QLIM_RST    4'h8
`define LCCD_MON_RST     2'h3
`define LCCD_MON_POS     14
`define LCCD_RESUME_POS  17
`define LCCD_KEEPBF_POS  23
`define LCCD_ALEN_POS    24
`define LCCD_EXT_POS     96
`define LCCD_ADDR_POS    112

// --------------------------------------------------------------------
// register map and events
// --------------------------------------------------------------------
`define LCCD_REG_MODE    8'h00
`define LCCD_REG_EVT     8'h04
`define LCCD_REG_CLR     8'h08
`define LCCD_REG_EN      8'h0C
`define LCCD_REG_STATE   8'h10
`define LCCD_REG_ADR_LO  8'h14
`define LCCD_REG_ADR_HI  8'h18
`define LCCD_EVT_ADDR    0
`define LCCD_EVT_CFG     1
`define LCCD_EVT_ABORT   2

`endif

// ==== hdl/lccd_pkg.sv ====
package lccd_pkg;
  typedef enum logic [0:0] {
    LCCD_ST_IDLE = 1'h0,
    LCCD_ST_LOAD = 1'h1
  } lccd_state_t;

  typedef enum logic [1:0] {
    LCCD_MODE_LEGACY = 2'h0,
    LCCD_MODE_SEG    = 2'h1,
    LCCD_MODE_LINEAR = 2'h2,
    LCCD_MODE_RSVD   = 2'h3
  } lccd_mode_t;

  typedef enum logic [1:0] {
    LCCD_CMD_NONE = 2'h0,
    LCCD_CMD_ADDR = 2'h1,
    LCCD_CMD_CFG  = 2'h2
  } lccd_cmd_t;
endpackage

// ==== hdl/lccd_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "lccd_params.svh"
module lccd_top
  import lccd_pkg::*;
(
  // clock and reset
  input  wire  logic         i_clk,
  input  wire  logic         i_reset_n,
  input  wire  logic         i_clk_en,
  // command block words from the command unit
  input  wire  logic         i_word_valid,
  input  wire  logic         i_word_first,
  input  wire  logic [31:0]  i_word,
  input  wire  logic         i_abort,
  // status write-back and list control
  output logic               o_stat_wr,
  output logic       [15:0]  o_stat_word,
  output logic               o_suspend,
  output logic               o_list_end,
  output logic               o_cmd_irq,
  output logic               o_busy,
  // loaded settings
  output logic       [47:0]  o_station_address,
  output logic       [111:0] o_cfg_bytes,
  output logic       [3:0]   o_queue_limit,
  output logic       [1:0]   o_monitor,
  output logic               o_resume_reread,
  output logic               o_keep_bad_frames,
  output logic               o_prefetch_mark,
  output logic       [15:0]  o_ext_cfg,
  // register port
  input  wire  logic [7:0]   i_addr,
  input  wire  logic [31:0]  i_wdata,
  input  wire  logic         i_wr,
  input  wire  logic         i_rd,
  output logic       [31:0]  o_rdata,
  output logic               o_irq
);

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  lccd_state_t state_q;
  lccd_cmd_t   cmd_q;
  lccd_mode_t  mode_q;
  logic [3:0]  widx_q;
  logic [4:0]  cnt_q;
  logic        flag_last_q;
  logic        flag_s_q;
  logic        flag_i_q;
  logic [2:0]  evt_q;
  logic [2:0]  en_q;
  logic        addr_seen_q;
  logic [159:0] bytes;

  // ------------------------------------------------------------------
  // decode of the first word
  // ------------------------------------------------------------------
  wire [2:0] opc      = i_word[`LCCD_OPC_HI:`LCCD_OPC_LO];
  wire       idle     = (state_q == LCCD_ST_IDLE);
  wire       run      = (state_q == LCCD_ST_LOAD);
  wire       head     = idle && i_word_valid && i_word_first;
  wire       is_addr  = (opc == `LCCD_OPC_ADDR);
  wire       is_cfg   = (opc == `LCCD_OPC_CFG);
  wire       start    = head && (is_addr || is_cfg);
  wire       legacy   = (mode_q == LCCD_MODE_LEGACY);
  wire       seg_lay  = legacy || (mode_q == LCCD_MODE_SEG);

  // ------------------------------------------------------------------
  // byte positions: legacy and segmented put byte 0 at block byte 6,
  // linear at byte 8 behind the 32-bit link address
  // ------------------------------------------------------------------
  wire [5:0] off      = seg_lay ? `LCCD_OFF_SEG : `LCCD_OFF_LIN;
  wire       hdr_word = run && i_word_valid && (widx_q == off[5:2]);
  wire       past_hdr = (widx_q >= off[5:2]);
  wire [7:0] b0       = off[1] ? i_word[23:16] : i_word[7:0];
  wire [4:0] cnt_raw  = hdr_word ? {1'b0, b0[3:0]} : cnt_q;

  // count clamp differs per mode; 15 in newer modes stops at 14 bytes
  wire [4:0] cnt_leg  = (cnt_raw > `LCCD_CNT_LEG_MAX) ? `LCCD_CNT_LEG_MAX :
                        (cnt_raw < `LCCD_CNT_LEG_MIN) ? `LCCD_CNT_LEG_MIN :
                        cnt_raw;
  wire [4:0] cnt_new  = (cnt_raw > `LCCD_CNT_NEW_MAX) ? `LCCD_CNT_NEW_MAX :
                        cnt_raw;
  wire [4:0] cnt_eff  = legacy ? cnt_leg : cnt_new;

  // address length from loaded byte 3; default byte gives six
  wire [4:0] alen_raw = {2'b00, bytes[`LCCD_ALEN_POS +: 3]};
  wire [4:0] alen_eff = (alen_raw > `LCCD_ADDR_MAX) ? `LCCD_ADDR_MAX :
                        alen_raw;
  wire [4:0] need     = (cmd_q == LCCD_CMD_CFG) ? cnt_eff : alen_eff;

  // ------------------------------------------------------------------
  // per-lane write enables
  // ------------------------------------------------------------------
  logic [3:0]  lane_we;
  logic [19:0] lane_idx;
  genvar l;
  generate
    for (l = 0; l < 4; l++) begin : g_lane
      wire [6:0] pos  = {1'b0, widx_q, 2'(l)};
      wire [6:0] rel  = pos - {1'b0, off};
      wire       rng  = (pos >= {1'b0, off}) && (rel < {2'b00, need});
      // only the counted bytes are touched
      assign lane_we[l] = run && i_word_valid && !i_abort && rng;
      assign lane_idx[5*l +: 5] = (cmd_q == LCCD_CMD_ADDR) ?
                                  (rel[4:0] + `LCCD_ADDR_BASE) : rel[4:0];
    end
  endgenerate

  wire [6:0] end_pos = {1'b0, widx_q, 2'b11} + 7'h01;
  wire [6:0] lim_pos = {1'b0, off} + {2'b00, need};
  wire       fin     = run && i_word_valid && past_hdr && (end_pos >= lim_pos);
  wire       abort   = run && i_abort;
  wire       finish  = abort || fin;

  // ------------------------------------------------------------------
  // byte storage: 14 parameter bytes and 6 address bytes
  // ------------------------------------------------------------------
  lccd_byte_store #(
    .N_BYTES (`LCCD_ALL_BYTES),
    .DFLT    (`LCCD_DFLT)
  ) u_store (
    .i_clk       (i_clk),
    .i_reset_n   (i_reset_n),
    .i_clk_en    (i_clk_en),
    .i_lane_we   (lane_we),
    .i_lane_idx  (lane_idx),
    .i_lane_data (i_word),
    .o_bytes     (bytes)
  );

  // address bytes go out unmodified, lowest bit included
  // reset value all ones until the first load
  assign o_station_address = bytes[`LCCD_ADDR_POS +: 48];
  assign o_cfg_bytes       = bytes[111:0];

  // ------------------------------------------------------------------
  // command sequencing
  // ------------------------------------------------------------------
  lccd_state_t state_d;
  assign state_d = start  ? LCCD_ST_LOAD :
                   finish ? LCCD_ST_IDLE : state_q;

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_q   <= LCCD_ST_IDLE;
      cmd_q     <= LCCD_CMD_NONE;
      widx_q    <= 4'h0;
      cnt_q     <= 5'h00;
      flag_last_q <= 1'b0;
      flag_s_q  <= 1'b0;
      flag_i_q  <= 1'b0;
      o_busy    <= 1'b0;
    end else if (i_clk_en) begin
      state_q <= state_d;
      o_busy  <= (state_d == LCCD_ST_LOAD);
      if (start) begin
        cmd_q     <= is_addr ? LCCD_CMD_ADDR : LCCD_CMD_CFG;
        widx_q    <= 4'h1;
        flag_last_q <= i_word[`LCCD_BIT_LAST];
        flag_s_q  <= i_word[`LCCD_BIT_S];
        flag_i_q  <= i_word[`LCCD_BIT_I];
      end else if (run && i_word_valid && (widx_q != 4'hF)) begin
        widx_q <= widx_q + 4'h1;
      end
      if (hdr_word) begin
        cnt_q <= cnt_raw;
      end
    end
  end

  // ------------------------------------------------------------------
  // completion: C and B in one write, with suspend, list end and irq in the same cycle
  // ------------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_stat_wr   <= 1'b0;
      o_stat_word <= 16'h0000;
      o_suspend   <= 1'b0;
      o_list_end  <= 1'b0;
      o_cmd_irq   <= 1'b0;
    end else if (i_clk_en) begin
      o_stat_wr  <= finish;
      o_suspend  <= finish && flag_s_q;
      o_list_end <= finish && flag_last_q;
      o_cmd_irq  <= finish && flag_i_q;
      if (finish) begin
        o_stat_word              <= 16'h0000;
        o_stat_word[`LCCD_ST_C]  <= 1'b1;
        o_stat_word[`LCCD_ST_B]  <= 1'b0;
        o_stat_word[`LCCD_ST_OK] <= !abort;
        o_stat_word[`LCCD_ST_A]  <= abort;
      end
    end
  end

  // ------------------------------------------------------------------
  // decoded settings, registered so every output comes from a flop
  // ------------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_queue_limit     <= `LCCD_QLIM_RST;
      o_monitor         <= `LCCD_MON_RST;
      o_resume_reread   <= 1'b0;
      o_keep_bad_frames <= 1'b0;
      o_prefetch_mark   <= 1'b0;
      o_ext_cfg         <= 16'h0000;
    end else if (i_clk_en) begin
      o_queue_limit     <= bytes[`LCCD_QLIM_POS +: 4];
      o_monitor         <= bytes[`LCCD_MON_POS +: 2];
      o_resume_reread   <= bytes[`LCCD_RESUME_POS];
      o_keep_bad_frames <= bytes[`LCCD_KEEPBF_POS];
      // prefetched mark has no effect in legacy mode
      o_prefetch_mark   <= bytes[`LCCD_PREF_POS] && !legacy;
      // extra features held off in legacy whatever was loaded
      o_ext_cfg         <= legacy ? 16'h0000 : bytes[`LCCD_EXT_POS +: 16];
    end
  end

  // ------------------------------------------------------------------
  // register port
  // ------------------------------------------------------------------
  wire       wr_mode = i_wr && (i_addr == `LCCD_REG_MODE);
  wire       wr_clr  = i_wr && (i_addr == `LCCD_REG_CLR);
  wire       wr_en   = i_wr && (i_addr == `LCCD_REG_EN);
  wire [2:0] ev_set;
  assign ev_set[`LCCD_EVT_ADDR]  = fin && !abort && (cmd_q == LCCD_CMD_ADDR);
  assign ev_set[`LCCD_EVT_CFG]   = fin && !abort && (cmd_q == LCCD_CMD_CFG);
  assign ev_set[`LCCD_EVT_ABORT] = abort;
  wire [2:0] ev_clr  = wr_clr ? i_wdata[2:0] : 3'h0;
  // a new event wins over a clear landing in the same cycle
  wire [2:0] evt_d   = (evt_q & ~ev_clr) | ev_set;
  wire [2:0] en_d    = wr_en ? i_wdata[2:0] : en_q;

  wire [31:0] rd_mux =
    (i_addr == `LCCD_REG_MODE)   ? {30'h0, mode_q} :
    (i_addr == `LCCD_REG_EVT)    ? {29'h0, evt_q} :
    (i_addr == `LCCD_REG_EN)     ? {29'h0, en_q} :
    (i_addr == `LCCD_REG_STATE)  ? {22'h0, widx_q, cnt_q, o_busy} :
    (i_addr == `LCCD_REG_ADR_LO) ? o_station_address[31:0] :
    (i_addr == `LCCD_REG_ADR_HI) ? {16'h0, o_station_address[47:32]} :
    32'h0000_0000;

  // mode changes mid-command are taken at once; software sets it first
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      mode_q  <= LCCD_MODE_LEGACY;
      evt_q   <= 3'h0;
      en_q    <= 3'h0;
      o_irq   <= 1'b0;
      o_rdata <= 32'h0000_0000;
    end else if (i_clk_en) begin
      if (wr_mode) begin
        mode_q <= lccd_mode_t'(i_wdata[1:0]);
      end
      evt_q   <= evt_d;
      en_q    <= en_d;
      o_irq   <= |(evt_d & en_d);
      o_rdata <= i_rd ? rd_mux : 32'h0000_0000;
    end
  end

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      addr_seen_q <= 1'b0;
    end else if (i_clk_en && run && (cmd_q == LCCD_CMD_ADDR) && (|lane_we)) begin
      addr_seen_q <= 1'b1;
    end
  end

  AST_OPC_ADDR: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_clk_en && head && opc == `LCCD_OPC_ADDR)
      |=> (o_busy && cmd_q == LCCD_CMD_ADDR))
    else $error("address load opcode not taken");

  AST_OPC_CFG: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_clk_en && head && opc == `LCCD_OPC_CFG)
      |=> (o_busy && cmd_q == LCCD_CMD_CFG))
    else $error("parameter load opcode not taken");

  AST_ONE_WRITE: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    o_stat_wr |-> (o_stat_word[`LCCD_ST_C] && !o_stat_word[`LCCD_ST_B]))
    else $error("done and busy not written together");

  AST_ABORT_BIT: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_clk_en && run && i_abort)
      |=> (o_stat_wr && o_stat_word[`LCCD_ST_A] && !o_stat_word[`LCCD_ST_OK]))
    else $error("abort not reported");

  AST_OK_BIT: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_clk_en && fin && !i_abort)
      |=> (o_stat_wr && o_stat_word[`LCCD_ST_OK] && !o_stat_word[`LCCD_ST_A]
           && (o_list_end == $past(flag_last_q))))
    else $error("clean completion misreported");

  AST_BCAST: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    !addr_seen_q |-> (o_station_address == 48'hFFFF_FFFF_FFFF))
    else $error("station address left broadcast early");

  AST_CLAMP: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (legacy && cmd_q == LCCD_CMD_CFG && hdr_word)
      |-> (cnt_eff >= `LCCD_CNT_LEG_MIN && cnt_eff <= `LCCD_CNT_LEG_MAX))
    else $error("legacy count out of range");

  AST_LEGACY_EXT: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_clk_en && legacy) |=> (o_ext_cfg == 16'h0000 && !o_prefetch_mark))
    else $error("extended features on in legacy mode");

  AST_ADDR_LEN: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (cmd_q == LCCD_CMD_ADDR && run) |-> (need <= `LCCD_ADDR_MAX))
    else $error("address length above six");

  AST_BUSY_END: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_clk_en && finish) |=> (!o_busy ##1 !o_stat_wr))
    else $error("busy kept after completion");

endmodule
`default_nettype wire

// ==== verif/lan_config_command_decoder_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module lan_config_command_decoder_tb;
  logic         i_clk, i_reset_n, i_clk_en, i_abort, i_wr, i_rd;
  logic         i_word_valid, i_word_first, o_irq;
  logic [31:0]  i_word, i_wdata, o_rdata, rd_q;
  logic [7:0]   i_addr;
  logic         o_stat_wr, o_suspend, o_list_end, o_cmd_irq, o_busy;
  logic         o_resume_reread, o_keep_bad_frames, o_prefetch_mark;
  logic [15:0]  o_stat_word, o_ext_cfg;
  logic [47:0]  o_station_address;
  logic [111:0] o_cfg_bytes;
  logic [3:0]   o_queue_limit;
  logic [1:0]   o_monitor;
  logic         seen;
  int           fails, num_checks, cyc;

  lccd_top uut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_clk_en(i_clk_en),
    .i_word_valid(i_word_valid), .i_word_first(i_word_first), .i_word(i_word),
    .i_abort(i_abort), .o_stat_wr(o_stat_wr), .o_stat_word(o_stat_word),
    .o_suspend(o_suspend), .o_list_end(o_list_end), .o_cmd_irq(o_cmd_irq),
    .o_busy(o_busy), .o_station_address(o_station_address),
    .o_cfg_bytes(o_cfg_bytes), .o_queue_limit(o_queue_limit), .o_monitor(o_monitor),
    .o_resume_reread(o_resume_reread), .o_keep_bad_frames(o_keep_bad_frames),
    .o_prefetch_mark(o_prefetch_mark), .o_ext_cfg(o_ext_cfg), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq));

  lccd_host_model host (.i_clk(i_clk), .o_valid(i_word_valid),
    .o_first(i_word_first), .o_word(i_word));

  always #50 i_clk = ~i_clk;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] w0(input logic [2:0] opc, input logic lst, s, i);
    return {lst, s, i, 10'h000, opc, 16'h0000};
  endfunction

  task automatic chk(input string n, input logic [111:0] e, g);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s: expected %0h seen %0h", n, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge i_clk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 rd_q = o_rdata;
  endtask

  // bounded wait for the status write-back pulse
  task automatic done_wait();
    #1;
    for (int k = 0; k < 20 && o_stat_wr !== 1'b1; k++) begin
      @(posedge i_clk);
      #1;
    end
    chk("stat_wr", 1, o_stat_wr);
  endtask

  task automatic run(input int gap);
    host.send(gap);
    done_wait();
  endtask

  task automatic settle();
    @(posedge i_clk);
    #1;
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // hang guard, well above the hundred or so cycles needed
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      summarize();
    end
  end

  // ------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------
  initial begin
    {i_clk, i_reset_n, i_abort, i_wr, i_rd} = '0;
    {i_clk_en, i_addr, i_wdata} = {1'b1, 40'h0};
    repeat (12) @(posedge i_clk);
    i_reset_n <= 1'b1;
    #1 chk("station", 48'hFFFFFFFFFFFF, o_station_address);
    chk("bytes1_2", 16'h40C8, o_cfg_bytes[23:8]);
    chk("qlim_mon", 6'h38, {o_monitor, o_queue_limit});
    $display("test reset done");
    host.q = '{w0(3'h1, 1, 0, 1), 32'h2301FFFF, 32'hAB896745};
    run(1);
    chk("stat", 16'hA000, o_stat_word);
    chk("flags", 3'h5, {o_list_end, o_suspend, o_cmd_irq});
    chk("station", 48'hAB8967452301, o_station_address);
    $display("test address done");
    host.q = '{w0(3'h2, 0, 1, 0), 32'h05820000, 32'h77772482};
    run(0);
    chk("suspend", 1, o_suspend);
    chk("legacy_min", 48'h600024820582, o_cfg_bytes[47:0]);
    settle();
    chk("qlim", 4'h5, o_queue_limit);
    chk("monitor", 2'h0, o_monitor);
    chk("resume", 1, o_resume_reread);
    chk("keep_bf", 1, o_keep_bad_frames);
    chk("pmark_leg", 0, o_prefetch_mark);
    host.q = '{w0(3'h1, 0, 0, 0), 32'hDDCC0000, 32'h9988FFEE};
    run(0);
    chk("station4", 48'hAB89FFEEDDCC, o_station_address);
    host.q = '{w0(3'h2, 0, 0, 0), 32'h050F0000, 32'h60002482, 32'h0, 32'h5555FF40};
    run(0);
    chk("legacy_max", 32'h0000FF40, o_cfg_bytes[111:80]);
    settle();
    chk("ext_leg", 16'h0000, o_ext_cfg);
    $display("test legacy done");
    wr(8'h00, 32'h1);
    host.q = '{w0(3'h2, 0, 0, 0), 32'h05840000, 32'h60002482};
    run(1);
    chk("byte0", 8'h84, o_cfg_bytes[7:0]);
    settle();
    chk("ext_dflt", 16'h0000, o_ext_cfg);
    chk("pmark", 1, o_prefetch_mark);
    host.q = '{w0(3'h2, 0, 0, 0), 32'h058F0000, 32'h60002482, 32'h0, 32'hBEEFFF40};
    run(0);
    settle();
    chk("ext", 16'hBEEF, o_ext_cfg);
    wr(8'h00, 32'h2);
    host.q = '{w0(3'h2, 0, 0, 0), 32'h00001000, 32'h24020904};
    run(0);
    chk("linear", 32'h24020904, o_cfg_bytes[31:0]);
    settle();
    chk("qlim_lin", 4'h9, o_queue_limit);
    chk("keep_off", 0, o_keep_bad_frames);
    wr(8'h00, 32'h0);
    settle();
    chk("ext_off", 16'h0000, o_ext_cfg);
    wr(8'h00, 32'h2);
    $display("test newer modes done");
    host.q = '{w0(3'h1, 0, 0, 0), 32'h11110000};
    host.send(0);
    #1 chk("busy", 1, o_busy);
    @(posedge i_clk);
    i_clk_en <= 1'b0;
    i_abort  <= 1'b1;
    repeat (3) @(posedge i_clk);
    #1 chk("frozen", 2'h2, {o_busy, o_stat_wr});
    @(posedge i_clk);
    i_clk_en <= 1'b1;
    @(posedge i_clk);
    i_abort <= 1'b0;
    done_wait();
    chk("abort_stat", 16'h9000, o_stat_word);
    host.q = '{w0(3'h0, 1, 1, 1)};
    host.send(0);
    seen = 1'b0;
    repeat (4) begin
      settle();
      seen = seen | o_stat_wr | o_busy;
    end
    chk("other_opc", 0, seen);
    $display("test abort done");
    rd(8'h04);
    chk("events", 32'h7, rd_q);
    chk("irq_off", 0, o_irq);
    wr(8'h0C, 32'h4);
    #1 chk("irq_on", 1, o_irq);
    rd(8'h0C);
    chk("enable", 32'h4, rd_q);
    rd(8'h00);
    chk("mode", 32'h2, rd_q);
    wr(8'h08, 32'h4);
    #1 chk("irq_clr", 0, o_irq);
    rd(8'h04);
    chk("events_clr", 32'h3, rd_q);
    rd(8'h08);
    chk("clear_rd", 32'h0, rd_q);
    rd(8'h40);
    chk("unmapped", 32'h0, rd_q);
    rd(8'h14);
    chk("adr_lo", 32'hFFEEDDCC, rd_q);
    rd(8'h18);
    chk("adr_hi", 32'h0000AB89, rd_q);
    $display("test registers done");
    summarize();
  end
endmodule
`default_nettype wire

// ==== verif/lccd_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module lccd_host_model (
  // clock
  input  wire logic        i_clk,
  // command block words
  output logic             o_valid,
  output logic             o_first,
  output logic      [31:0] o_word
);
  logic [31:0] q[$];

  initial begin
    o_valid = 1'b0;
    o_first = 1'b0;
    o_word  = 32'h0;
  end

  // ------------------------------------------------------------
  // block fetch: one word per valid, gap > 0 stalls between words
  // ------------------------------------------------------------
  // released word line shows the inverse, never a stale copy
  task automatic send(input int gap);
    logic [31:0] w;
    for (int k = 0; k < q.size(); k++) begin
      w = q[k];
      @(posedge i_clk);
      o_valid <= 1'b1;
      o_first <= (k == 0);
      o_word  <= w;
      if (gap > 0 || k == q.size() - 1) begin
        @(posedge i_clk);
        o_valid <= 1'b0;
        o_first <= 1'b0;
        o_word  <= ~w;
      end
    end
  endtask
endmodule
`default_nettype wire
